// ==== core/bfa_fault_action.sv ====
`timescale 1ns/1ps
// Behaviour
// - Power-on or regulator undervoltage forces all gates off.
// - Enabled watchdog timeout forces all gates off.
// - Logic overvoltage, overtemperature: all off if stop-all.
// - Stop-all: DRAIN_SOURCE_VOLTAGE/bootstrap fault latches all gates off.
// - No stop-all: latch affected gate, release on command.
// - Non-latching faults last only while detected.
// - Latches release on reset pin, power-on, read.
// - Fault bits clear only on power-on or read.
// - Other faults except main supply undervoltage leave gate outputs enabled.
// - Mask bit disables diagnostic completely.
// - Power-on, serial error, overtemperature are unmaskable.
// - DRAIN_SOURCE_VOLTAGE fault sets per-MOSFET diagnostic bit.
module bfa_fault_action (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bfa_pkg::BFA_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Active-low fault reset pin, asynchronous to pclk.
    input wire logic fault_reset_n,
    // Detector levels, all on pclk, high while the fault is detected.
    input wire logic por_fault,
    input wire logic gate_drive_regulator_uv,
    input wire logic [bfa_pkg::BFA_NUM_FETS-1:0] bootstrap_uv,
    input wire logic logic_terminal_ov,
    input wire logic watchdog_timeout,
    input wire logic over_temp,
    input wire logic [bfa_pkg::BFA_NUM_FETS-1:0] drain_source_voltage_fault,
    input wire logic serial_error,
    input wire logic logic_supply_rail_uv,
    input wire logic logic_supply_rail_ov,
    input wire logic gate_drive_regulator_ov,
    input wire logic main_supply_uv,
    input wire logic main_supply_ov,
    input wire logic gate_source_voltage_uv,
    input wire logic temp_warning,
    input wire logic over_current,
    input wire logic open_load,
    // Gate commands in, gated drives out.
    input wire logic [bfa_pkg::BFA_NUM_FETS-1:0] gate_cmd,
    output logic [bfa_pkg::BFA_NUM_FETS-1:0] gate_out,
    output logic fault_active
);
    import bfa_pkg::*;

    // Sticky update: set wins over the read clear, power-on clears the rest.
    function automatic logic [BFA_NUM_FAULTS-1:0] sticky_next(
        input logic [BFA_NUM_FAULTS-1:0] cur,
        input logic [BFA_NUM_FAULTS-1:0] set,
        input logic [BFA_NUM_FAULTS-1:0] clr,
        input logic por
    );
        sticky_next = por ? set : ((cur & ~clr) | set);
    endfunction

    // Software-visible registers.
    logic stop_all_on_fault; // Stop every gate on stop-all class faults.
    logic enable_watchdog_on; // Lets a watchdog timeout act on the gates.
    logic [BFA_NUM_FAULTS-1:0] mask; // One bit per diagnostic, set disables it.
    logic [BFA_NUM_FAULTS-1:0] status; // Sticky fault bits.
    logic [BFA_DIAG_W-1:0] diag; // Sticky per-MOSFET DRAIN_SOURCE_VOLTAGE and bootstrap bits.

    // Internal fault state.
    logic latch_all; // Latched all-gates-off state.
    logic [BFA_NUM_FETS-1:0] latch_fet; // Latched single-gate-off states.
    logic [BFA_NUM_FETS-1:0] gate_cmd_d; // Previous command, for on-edges.
    logic reset_sync_n; // Synchronised fault reset pin.

    // The reset pin is asynchronous, so it passes two flip-flops first.
    bfa_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_reset_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(fault_reset_n),
        .q(reset_sync_n)
    );

    // APB decode. The slave never inserts wait states.
    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable;
    wire hit_ctrl = (paddr == BFA_OFF_CTRL);
    wire hit_mask = (paddr == BFA_OFF_MASK);
    wire hit_status = (paddr == BFA_OFF_STATUS);
    wire hit_diag = (paddr == BFA_OFF_DIAG);
    wire hit_state = (paddr == BFA_OFF_STATE);
    wire hit_any = hit_ctrl | hit_mask | hit_status | hit_diag | hit_state;
    wire wr_ctrl = apb_access & pwrite & hit_ctrl;
    wire wr_mask = apb_access & pwrite & hit_mask;
    wire rd_status = apb_access & ~pwrite & hit_status;
    wire rd_diag = apb_access & ~pwrite & hit_diag;
    // Zero wait states keep the master simple; a slower decode would need pready logic.
    assign pready = 1'b1;
    // Unmapped addresses answer with an error and read as zero.
    assign pslverr = apb_access & ~hit_any;

    // Raw detector vector in status bit order.
    logic [BFA_NUM_FAULTS-1:0] raw_fault;
    assign raw_fault[BFA_ST_POR] = por_fault;
    assign raw_fault[BFA_ST_REG_UV] = gate_drive_regulator_uv;
    assign raw_fault[BFA_ST_BOOT_UV] = |bootstrap_uv;
    assign raw_fault[BFA_ST_LOGIC_OV] = logic_terminal_ov;
    assign raw_fault[BFA_ST_WATCHDOG] = watchdog_timeout;
    assign raw_fault[BFA_ST_OVER_TEMP] = over_temp;
    assign raw_fault[BFA_ST_VDS] = |drain_source_voltage_fault;
    assign raw_fault[BFA_ST_SERIAL] = serial_error;
    assign raw_fault[BFA_ST_RAIL_UV] = logic_supply_rail_uv;
    assign raw_fault[BFA_ST_RAIL_OV] = logic_supply_rail_ov;
    assign raw_fault[BFA_ST_REG_OV] = gate_drive_regulator_ov;
    assign raw_fault[BFA_ST_SUPPLY_UV] = main_supply_uv;
    assign raw_fault[BFA_ST_SUPPLY_OV] = main_supply_ov;
    assign raw_fault[BFA_ST_GS_UV] = gate_source_voltage_uv;
    assign raw_fault[BFA_ST_TEMP_WARN] = temp_warning;
    assign raw_fault[BFA_ST_OVER_CURRENT] = over_current;
    assign raw_fault[BFA_ST_OPEN_LOAD] = open_load;

    // A masked diagnostic produces no state, flag or bit at all.
    wire [BFA_NUM_FAULTS-1:0] qual = raw_fault & ~mask;
    wire [BFA_NUM_FETS-1:0] vds_q = drain_source_voltage_fault & {BFA_NUM_FETS{~mask[BFA_ST_VDS]}};
    wire [BFA_NUM_FETS-1:0] boot_q = bootstrap_uv & {BFA_NUM_FETS{~mask[BFA_ST_BOOT_UV]}};
    wire [BFA_NUM_FETS-1:0] fet_fault = vds_q | boot_q;

    // Critical conditions stop all gates whatever stop-all says, unlatched.
    wire crit_off = qual[BFA_ST_POR] | qual[BFA_ST_REG_UV]
        | (enable_watchdog_on & qual[BFA_ST_WATCHDOG])
        | qual[BFA_ST_SUPPLY_UV];
    // Power-on also clears the latches below; here it only holds the gates low.
    // Stop-all class faults act only while present, and only with stop-all set.
    wire stop_all_off = stop_all_on_fault
        & (qual[BFA_ST_LOGIC_OV] | qual[BFA_ST_OVER_TEMP]
        | (|fet_fault));
    // Every other diagnostic reaches the status bits and fault_active only, never the gates.
    wire all_off = crit_off | stop_all_off | latch_all;
    // With stop-all clear a gate that is switched on every PWM period releases its
    // latch each time, so a lasting short trips again once per period.
    // A single gate is off while its fault is seen or its latch holds.
    wire [BFA_NUM_FETS-1:0] fet_off = latch_fet | (fet_fault & {BFA_NUM_FETS{~stop_all_on_fault}});

    // Latch set and release terms.
    wire latch_all_set = stop_all_on_fault & (|fet_fault);
    wire latch_clr = ~reset_sync_n | rd_diag;
    wire [BFA_NUM_FETS-1:0] latch_fet_set = fet_fault & {BFA_NUM_FETS{~stop_all_on_fault}};
    wire [BFA_NUM_FETS-1:0] cmd_rise = gate_cmd & ~gate_cmd_d;
    // Reading a MOSFET's diagnostic bits releases only that MOSFET's latch.
    wire [BFA_NUM_FETS-1:0] fet_rd = rd_diag ? (prdata[BFA_NUM_FETS-1:0]
        | prdata[BFA_DIAG_BOOT_LSB+BFA_NUM_FETS-1:BFA_DIAG_BOOT_LSB]) : 4'h0;
    // The pin release is a level: a fault seen while the pin is still low latches
    // again, because a set beats every release except power-on.
    wire [BFA_NUM_FETS-1:0] fet_clr = {BFA_NUM_FETS{~reset_sync_n}} | fet_rd | cmd_rise;

    // Any active source holds a gate low; only the last release frees it.
    wire [BFA_NUM_FETS-1:0] next_gate_out = gate_cmd & ~fet_off
        & ~{BFA_NUM_FETS{all_off}};
    wire next_fault_active = all_off | (|fet_off) | (|qual);

    // Read clears only the bits the master was actually shown in setup.
    wire [BFA_NUM_FAULTS-1:0] status_clr = rd_status ? prdata[BFA_NUM_FAULTS-1:0] : 17'h00000;
    wire [BFA_NUM_FAULTS-1:0] diag_clr = rd_diag ? {9'h000, prdata[BFA_DIAG_W-1:0]} : 17'h00000;
    wire [BFA_NUM_FAULTS-1:0] diag_set = {9'h000, boot_q, vds_q};
    wire [BFA_NUM_FAULTS-1:0] next_status = sticky_next(status, qual, status_clr, por_fault);
    wire [BFA_NUM_FAULTS-1:0] next_diag_w = sticky_next({9'h000, diag}, diag_set, diag_clr,
        por_fault);

    // Read multiplexer, sampled into prdata during the setup cycle.
    wire [31:0] rd_mux = hit_ctrl ? {30'h00000000, enable_watchdog_on, stop_all_on_fault}
        : hit_mask ? {15'h0000, mask}
        : hit_status ? {15'h0000, status}
        : hit_diag ? {24'h000000, diag}
        : hit_state ? {22'h000000, all_off, latch_all, latch_fet, gate_out}
        : 32'h00000000;

    // Configuration registers change only on an explicit write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {enable_watchdog_on, stop_all_on_fault} <= BFA_CTRL_RESET;
            mask <= BFA_MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                stop_all_on_fault <= pwdata[BFA_CTRL_STOP_ALL_BIT];
                enable_watchdog_on <= pwdata[BFA_CTRL_WATCHDOG_BIT];
            end
            // Unmaskable diagnostics keep their mask bits at zero.
            if (wr_mask) begin
                mask <= pwdata[BFA_NUM_FAULTS-1:0] & ~BFA_MASK_FIXED_ZERO;
            end
        end
    end

    // Read data is registered at setup so the read clear matches what is returned.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Sticky bits ignore the reset pin; only power-on or a read clears them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 17'h00000;
            diag <= 8'h00;
        end else begin
            status <= next_status;
            diag <= next_diag_w[BFA_DIAG_W-1:0];
        end
    end

    // Latched fault states. A new fault beats a release in the same cycle,
    // except power-on, which is itself an all-off condition.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_all <= 1'b0;
            latch_fet <= 4'h0;
        end else if (por_fault) begin
            latch_all <= 1'b0;
            latch_fet <= 4'h0;
        end else begin
            latch_all <= latch_all_set | (latch_all & ~latch_clr);
            latch_fet <= latch_fet_set | (latch_fet & ~fet_clr);
        end
    end

    // Gate drives and fault flag come from flip-flops; faults that do not
    // latch therefore act one cycle after detection and end one after it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_cmd_d <= 4'h0;
            gate_out <= 4'h0;
            fault_active <= 1'b0;
        end else begin
            gate_cmd_d <= gate_cmd;
            gate_out <= next_gate_out;
            fault_active <= next_fault_active;
        end
    end

    // Checks on the gate and latch behaviour.
    default clocking bfa_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    por_all_off_a: assert property ((por_fault || (gate_drive_regulator_uv
        && !mask[BFA_ST_REG_UV])) |=> gate_out == 4'h0)
        else $error("gates not off after power-on or regulator undervoltage");
    watchdog_off_a: assert property ((enable_watchdog_on && watchdog_timeout
        && !mask[BFA_ST_WATCHDOG]) |=> gate_out == 4'h0)
        else $error("gates not off after watchdog timeout");
    stop_temp_off_a: assert property ((stop_all_on_fault && over_temp) ##1 over_temp
        |-> gate_out == 4'h0)
        else $error("gates not off on overtemperature with stop-all");
    latch_hold_a: assert property ((latch_all && reset_sync_n && !rd_diag
        && !por_fault) |=> latch_all && gate_out == 4'h0)
        else $error("all-off latch lost without a release");
    fet_release_a: assert property ((latch_fet[0] && cmd_rise[0]
        && !latch_fet_set[0]) |=> !latch_fet[0])
        else $error("gate latch not released by on command");
    pass_through_a: assert property ((!all_off && fet_off == 4'h0)
        |=> gate_out == $past(gate_cmd))
        else $error("gate blocked with no active disable source");
    pin_release_a: assert property ((!reset_sync_n && !latch_all_set
        && !latch_fet_set[2]) |=> !latch_all && !latch_fet[2])
        else $error("latch not released by fault reset pin");
    bits_keep_a: assert property ((!rd_status && !por_fault)
        |=> (status & $past(status)) == $past(status))
        else $error("status bit cleared without read or power-on");
    // The fault reset pin must leave the DRAIN_SOURCE_VOLTAGE status bit where it is.
    pin_keeps_bits_a: assert property ((!reset_sync_n && !rd_status && !por_fault
        && status[BFA_ST_VDS]) |=> status[BFA_ST_VDS])
        else $error("fault reset pin cleared a status bit");
    mask_quiet_a: assert property ((mask[BFA_ST_RAIL_UV]
        && !status[BFA_ST_RAIL_UV]) |=> !status[BFA_ST_RAIL_UV])
        else $error("masked diagnostic set its bit");
    no_mask_a: assert property (over_temp |=> status[BFA_ST_OVER_TEMP]
        && !mask[BFA_ST_OVER_TEMP])
        else $error("overtemperature was masked");
    supply_off_a: assert property ((main_supply_uv && !mask[BFA_ST_SUPPLY_UV])
        |=> gate_out == 4'h0)
        else $error("gates not off on supply undervoltage");
    vds_bit_a: assert property ((drain_source_voltage_fault[3]
        && !mask[BFA_ST_VDS]) |=> diag[BFA_PHASE_B_HIGH_SIDE_FAULT])
        else $error("DRAIN_SOURCE_VOLTAGE fault did not set its diagnostic bit");
    single_off_a: assert property (fet_off[1] |=> !gate_out[1])
        else $error("gate driven while a source disables it");

    latch_all_c: cover property (!latch_all ##1 latch_all);
    fet_cycle_c: cover property (latch_fet[0] ##1 cmd_rise[0] ##1 !latch_fet[0]);
    status_clear_c: cover property (rd_status && status != 17'h00000);
    unmapped_c: cover property (pslverr);
    pin_release_c: cover property (!reset_sync_n && latch_all);

endmodule // bfa_fault_action

// ==== core/bfa_pkg.sv ====
// Shared constants for the bridge fault action block.
package bfa_pkg;

    // APB address width and register byte offsets.
    localparam int BFA_ADDR_W = 8;
    localparam logic [BFA_ADDR_W-1:0] BFA_OFF_CTRL = 8'h00;
    localparam logic [BFA_ADDR_W-1:0] BFA_OFF_MASK = 8'h04;
    localparam logic [BFA_ADDR_W-1:0] BFA_OFF_STATUS = 8'h08;
    localparam logic [BFA_ADDR_W-1:0] BFA_OFF_DIAG = 8'h0C;
    localparam logic [BFA_ADDR_W-1:0] BFA_OFF_STATE = 8'h10;

    // Control register field positions.
    localparam int BFA_CTRL_STOP_ALL_BIT = 0;
    localparam int BFA_CTRL_WATCHDOG_BIT = 1;

    // Status register bit positions, one per diagnostic.
    localparam int BFA_NUM_FAULTS = 17;
    localparam int BFA_ST_POR = 0;
    localparam int BFA_ST_REG_UV = 1;
    localparam int BFA_ST_BOOT_UV = 2;
    localparam int BFA_ST_LOGIC_OV = 3;
    localparam int BFA_ST_WATCHDOG = 4;
    localparam int BFA_ST_OVER_TEMP = 5;
    localparam int BFA_ST_VDS = 6;
    localparam int BFA_ST_SERIAL = 7;
    localparam int BFA_ST_RAIL_UV = 8;
    localparam int BFA_ST_RAIL_OV = 9;
    localparam int BFA_ST_REG_OV = 10;
    localparam int BFA_ST_SUPPLY_UV = 11;
    localparam int BFA_ST_SUPPLY_OV = 12;
    localparam int BFA_ST_GS_UV = 13;
    localparam int BFA_ST_TEMP_WARN = 14;
    localparam int BFA_ST_OVER_CURRENT = 15;
    localparam int BFA_ST_OPEN_LOAD = 16;

    // Mask bits that always read zero: power-on, serial error, overtemperature.
    localparam logic [BFA_NUM_FAULTS-1:0] BFA_MASK_FIXED_ZERO = 17'h000A1;

    // Gate index order, also the diagnostic bit order of the DRAIN_SOURCE_VOLTAGE bits.
    localparam int BFA_NUM_FETS = 4;
    localparam int BFA_PHASE_A_LOW_SIDE_FAULT = 0;
    localparam int BFA_PHASE_A_HIGH_SIDE_FAULT = 1;
    localparam int BFA_PHASE_B_LOW_SIDE_FAULT = 2;
    localparam int BFA_PHASE_B_HIGH_SIDE_FAULT = 3;
    localparam int BFA_DIAG_BOOT_LSB = 4;
    localparam int BFA_DIAG_W = 8;

    // Reset values.
    localparam logic [1:0] BFA_CTRL_RESET = 2'h0;
    localparam logic [BFA_NUM_FAULTS-1:0] BFA_MASK_RESET = 17'h00000;

endpackage

// ==== core/bfa_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for levels arriving from outside the clock domain.
module bfa_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous level in, synchronised level out.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // First stage, read only by the second stage.
    logic [WIDTH-1:0] meta;

    // Both stages reset to the inactive level so that nothing fires at release.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // bfa_sync

// ==== verif/bfa_ctrl_model.sv ====
`timescale 1ns/1ps
// Controller model: an APB master that only reads and writes the registers it is told to.
module bfa_ctrl_model (
    // Clock.
    input wire logic pclk,
    // Request lines.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [bfa_pkg::BFA_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    // Slave answer.
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import bfa_pkg::*;

    // The bus stays idle until the first transfer is asked for.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // One transfer, held until pready; the controller polls results, issues no test commands.
    task automatic apb(input logic w, input logic [BFA_ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait states are honoured; only the bench timeout ends a hang.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // bfa_ctrl_model

// ==== verif/bfa_fault_action_tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench: detector levels are driven by status bit index.
module bfa_fault_action_tb_top;
    import bfa_pkg::*;

    logic pclk = 1'b0; // Clock, 8 ns period.
    logic presetn = 1'b0; // Held low at start.
    logic fault_reset_n = 1'b1; // Fault reset pin, idle high.
    logic [BFA_NUM_FAULTS-1:0] det = '0; // Detector levels; bits 2 and 6 are unused here.
    logic [BFA_NUM_FETS-1:0] boot = '0; // Bootstrap undervoltage per gate.
    logic [BFA_NUM_FETS-1:0] drain_source_voltage = '0; // Drain-source fault per gate.
    logic [BFA_NUM_FETS-1:0] gate_cmd = 4'hF; // All gates commanded on.
    logic psel, penable, pwrite, pready, pslverr, fault_active;
    logic [BFA_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [BFA_NUM_FETS-1:0] gate_out;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    // Clock generator.
    always #4 pclk = ~pclk;

    bfa_fault_action i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_reset_n(fault_reset_n), .por_fault(det[BFA_ST_POR]),
        .gate_drive_regulator_uv(det[BFA_ST_REG_UV]), .bootstrap_uv(boot),
        .logic_terminal_ov(det[BFA_ST_LOGIC_OV]), .watchdog_timeout(det[BFA_ST_WATCHDOG]),
        .over_temp(det[BFA_ST_OVER_TEMP]), .drain_source_voltage_fault(drain_source_voltage),
        .serial_error(det[BFA_ST_SERIAL]), .logic_supply_rail_uv(det[BFA_ST_RAIL_UV]),
        .logic_supply_rail_ov(det[BFA_ST_RAIL_OV]), .gate_drive_regulator_ov(det[BFA_ST_REG_OV]),
        .main_supply_uv(det[BFA_ST_SUPPLY_UV]), .main_supply_ov(det[BFA_ST_SUPPLY_OV]),
        .gate_source_voltage_uv(det[BFA_ST_GS_UV]), .temp_warning(det[BFA_ST_TEMP_WARN]),
        .over_current(det[BFA_ST_OVER_CURRENT]), .open_load(det[BFA_ST_OPEN_LOAD]),
        .gate_cmd(gate_cmd), .gate_out(gate_out), .fault_active(fault_active));

    bfa_ctrl_model i_ctrl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Verdict and end of run.
    task automatic end_of_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Timeout: the whole run needs under a thousand cycles.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test;
        end
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Lets the one-cycle gate path land before outputs are looked at.
    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic wr(input logic [BFA_ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        i_ctrl.apb(1'b1, a, d, r, e);
    endtask

    // Read with the error flag compared as the top bit.
    task automatic rd(input logic [BFA_ADDR_W-1:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] r;
        logic e;
        i_ctrl.apb(1'b0, a, 32'h0, r, e);
        chk({e, r}, {eerr, exp});
    endtask

    // One level fault raised and dropped; status then holds exactly its bit unless masked.
    task automatic fault_case(input int idx, input logic all_off, input logic masked);
        @(posedge pclk) det[idx] <= 1'b1;
        settle;
        chk(gate_out, all_off ? 4'h0 : 4'hF);
        chk(fault_active, !masked);
        @(posedge pclk) det[idx] <= 1'b0;
        settle;
        chk(gate_out, 4'hF);
        chk(fault_active, 1'b0);
        rd(BFA_OFF_STATUS, masked ? 32'h0 : (32'h1 << idx), 1'b0);
    endtask

    // Reset values, refused address and read-only status.
    task automatic t_regs;
        rd(BFA_OFF_CTRL, 32'h0, 1'b0);
        rd(BFA_OFF_MASK, 32'h0, 1'b0);
        rd(BFA_OFF_STATUS, 32'h0, 1'b0);
        rd(BFA_OFF_DIAG, 32'h0, 1'b0);
        rd(BFA_OFF_STATE, 32'hF, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        wr(BFA_OFF_STATUS, 32'hFFFFFFFF);
        rd(BFA_OFF_STATUS, 32'h0, 1'b0);
    endtask

    // Critical faults turn every gate off only while present.
    task automatic t_critical;
        wr(BFA_OFF_CTRL, 32'h2);
        fault_case(BFA_ST_POR, 1'b1, 1'b0);
        fault_case(BFA_ST_REG_UV, 1'b1, 1'b0);
        fault_case(BFA_ST_SUPPLY_UV, 1'b1, 1'b0);
        fault_case(BFA_ST_WATCHDOG, 1'b1, 1'b0);
        wr(BFA_OFF_CTRL, 32'h0);
        @(posedge pclk) det[BFA_ST_WATCHDOG] <= 1'b1;
        settle;
        chk(gate_out, 4'hF);
        chk(fault_active, 1'b1);
        @(posedge pclk) det[BFA_ST_WATCHDOG] <= 1'b0;
        settle;
        rd(BFA_OFF_STATUS, 32'h10, 1'b0);
    endtask

    // Stop-all dependent faults and faults that never disable.
    task automatic t_stopall;
        for (int s = 0; s < 2; s++) begin
            wr(BFA_OFF_CTRL, 32'(s));
            fault_case(BFA_ST_LOGIC_OV, s[0], 1'b0);
            fault_case(BFA_ST_OVER_TEMP, s[0], 1'b0);
            for (int i = BFA_ST_SERIAL; i <= BFA_ST_OPEN_LOAD; i++) begin
                if (i != BFA_ST_SUPPLY_UV) begin
                    fault_case(i, 1'b0, 1'b0);
                end
            end
        end
    endtask

    // Without stop-all only the faulty gate latches off.
    task automatic t_single;
        wr(BFA_OFF_CTRL, 32'h0);
        for (int k = 0; k < BFA_NUM_FETS; k++) begin
            @(posedge pclk) drain_source_voltage[k] <= 1'b1;
            @(posedge pclk) drain_source_voltage[k] <= 1'b0;
            settle;
            chk(gate_out, 4'hF ^ (4'h1 << k));
            @(posedge pclk) gate_cmd[k] <= 1'b0;
            @(posedge pclk) gate_cmd[k] <= 1'b1;
            settle;
            chk(gate_out, 4'hF);
            rd(BFA_OFF_DIAG, 32'h1 << k, 1'b0);
            @(posedge pclk) boot[k] <= 1'b1;
            @(posedge pclk) boot[k] <= 1'b0;
            settle;
            chk(gate_out, 4'hF ^ (4'h1 << k));
            rd(BFA_OFF_DIAG, 32'h10 << k, 1'b0);
            settle;
            chk(gate_out, 4'hF);
        end
        rd(BFA_OFF_STATUS, 32'h44, 1'b0);
    endtask

    // Stop-all latch: released by the pin or a read, bits kept, other sources still hold.
    task automatic t_latch_all;
        wr(BFA_OFF_CTRL, 32'h1);
        @(posedge pclk) drain_source_voltage[2] <= 1'b1;
        @(posedge pclk) drain_source_voltage[2] <= 1'b0;
        repeat (3) settle;
        chk(gate_out, 4'h0);
        @(posedge pclk) fault_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        fault_reset_n <= 1'b1;
        repeat (2) settle;
        chk(gate_out, 4'hF);
        rd(BFA_OFF_DIAG, 32'h4, 1'b0);
        @(posedge pclk) boot[3] <= 1'b1;
        @(posedge pclk) boot[3] <= 1'b0;
        det[BFA_ST_LOGIC_OV] <= 1'b1;
        settle;
        rd(BFA_OFF_DIAG, 32'h80, 1'b0);
        settle;
        chk(gate_out, 4'h0);
        @(posedge pclk) det[BFA_ST_LOGIC_OV] <= 1'b0;
        settle;
        chk(gate_out, 4'hF);
        rd(BFA_OFF_DIAG, 32'h0, 1'b0);
        rd(BFA_OFF_STATUS, 32'h4C, 1'b0);
    endtask

    // Masked diagnostics vanish; the three fixed ones cannot be masked.
    task automatic t_mask;
        wr(BFA_OFF_MASK, 32'h1FFFF);
        rd(BFA_OFF_MASK, 32'h1FF5E, 1'b0);
        wr(BFA_OFF_CTRL, 32'h1);
        fault_case(BFA_ST_REG_UV, 1'b0, 1'b1);
        fault_case(BFA_ST_LOGIC_OV, 1'b0, 1'b1);
        fault_case(BFA_ST_OVER_TEMP, 1'b1, 1'b0);
        fault_case(BFA_ST_SERIAL, 1'b0, 1'b0);
        fault_case(BFA_ST_POR, 1'b1, 1'b0);
        @(posedge pclk) drain_source_voltage[1] <= 1'b1;
        @(posedge pclk) drain_source_voltage[1] <= 1'b0;
        settle;
        chk(gate_out, 4'hF);
        rd(BFA_OFF_DIAG, 32'h0, 1'b0);
        wr(BFA_OFF_MASK, 32'h0);
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_critical;
        t_stopall;
        t_single;
        t_latch_all;
        t_mask;
        end_of_test;
    end
endmodule // bfa_fault_action_tb_top
